/* File: rtl/dsc_pkg.sv */
// Constants, field layout and types of the decoder and servo configuration bank.
// Behaviour
// - Motor power capped at 37, 75, 100 percent
// - Motor drive off, PWM, PDM or constant velocity
// - Status pin shows servo interrupt, decoder bit or pin 1
// - DAC samples inverted when bit 2 set
// - Bit 3 swaps channel order and word select
// - Equalizer code 0011 is nominal and default
// - Codes 0001, 0010 over-equalize 30, 15 ns
// - Codes 0100, 0101 under-equalize 15, 30 ns
// - Audio source after concealment; bit 3 adds flags
// - Bits 2 and 0 set clock accuracy level
// - Both bits set turn audio output low
// - Speed bit 2 clear means fast crystal
// - Speed bit 2 set: bit 3 ignored, multiplier picks speed
// - Speed bit 3 selects double speed
// - Low bits choose stop, pause or operating
// - Off-track taken from versatile pin 1
// - Internal off-track; pin 1 readable via status
// - Separate left and right mutes on pins
// - Code 001x: pin 3 low, combined mute
// - Reset loads every documented initial value
// - Register E bit 3 picks 4x/8x range
// - Slow crystal with multiplier doubles speed
package dsc_pkg;

    // Register indices on the 4-bit address port.
    localparam logic [3:0] MOTOR_OUTPUT_CONFIG_OFS      = 4'h6;
    localparam logic [3:0] DAC_STATUS_SELECT_OFS        = 4'h7;
    localparam logic [3:0] PLL_EQUALIZER_OFS            = 4'h9;
    localparam logic [3:0] DIGITAL_AUDIO_OUT_CONFIG_OFS = 4'ha;
    localparam logic [3:0] SPEED_CONTROL_OFS            = 4'hb;
    localparam logic [3:0] VERSATILE_PIN_CONFIG_OFS     = 4'hc;
    localparam logic [3:0] SPEED_RANGE_OFS              = 4'he;

    // Indices that hold storage; all others ignore writes and read zero.
    localparam logic [15:0] BANK_MAP = 16'h5ec0;

    // Power-on values per index.
    localparam logic [15:0][3:0] BANK_RST = {4'h0, 4'h4, 4'h0, 4'h2, 4'h0, 4'h2, 4'h3, 4'h0,
                                             4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};

    // Field positions.
    localparam int DAC_INVERT_BIT   = 2;
    localparam int DAC_SWAP_BIT     = 3;
    localparam int EBU_AFTER_BIT    = 1;
    localparam int EBU_FLAGS_BIT    = 3;
    localparam int SPD_XTAL_BIT     = 2;
    localparam int SPD_DOUBLE_BIT   = 3;
    localparam int VP_EXT_OT_BIT    = 0;
    localparam int VP_SPLIT_BIT     = 1;
    localparam int VP_V3_HIGH_BIT   = 2;
    localparam int RANGE_FAST_BIT   = 3;

    // Motor power caps in percent of full scale.
    localparam int MOTOR_CAP_LO_PCT  = 37;
    localparam int MOTOR_CAP_MID_PCT = 75;
    localparam int MOTOR_CAP_HI_PCT  = 100;
    localparam logic [7:0] MOTOR_CAP_LO  = 8'(255 * MOTOR_CAP_LO_PCT / 100);
    localparam logic [7:0] MOTOR_CAP_MID = 8'(255 * MOTOR_CAP_MID_PCT / 100);
    localparam logic [7:0] MOTOR_CAP_HI  = 8'(255 * MOTOR_CAP_HI_PCT / 100);

    // Equalizer offsets in ns; positive is over-equalization.
    localparam logic signed [5:0] EQ_OVER_30  = 6'sd30;
    localparam logic signed [5:0] EQ_OVER_15  = 6'sd15;
    localparam logic signed [5:0] EQ_NOMINAL  = 6'sd0;
    localparam logic signed [5:0] EQ_UNDER_15 = -6'sd15;
    localparam logic signed [5:0] EQ_UNDER_30 = -6'sd30;

    // Motor drive modes.
    typedef enum logic [1:0] {
        DSC_MOTOR_OFF = 2'b00,
        DSC_MOTOR_PWM = 2'b01,
        DSC_MOTOR_PDM = 2'b10,
        DSC_MOTOR_CONSTANT_VELOCITY = 2'b11
    } dsc_motor_mode_t;

    // Operating state, Gray coded along stop, pause, run.
    typedef enum logic [1:0] {
        DSC_STOP_STANDBY  = 2'b00,
        DSC_PAUSE_STANDBY = 2'b01,
        DSC_OPERATING     = 2'b11
    } dsc_op_state_t;

endpackage

/* File: rtl/dsc_config_regs.sv */
// Configuration register bank with decoded controls for the decoder and servo.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module dsc_config_regs #(
    parameter int SAMPLE_W = 16
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  nrst_i,
    input  wire logic [3:0]            addr_i,
    input  wire logic [3:0]            wdata_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output logic [3:0]                 rdata_o,
    input  wire logic [7:0]            motor_cmd_i,
    input  wire logic                  motor_dir_i,
    output logic [7:0]                 motor_drive_out_a_o,
    output logic [7:0]                 motor_drive_out_b_o,
    output logic                       motor_drive_oe_o,
    output dsc_pkg::dsc_motor_mode_t   motor_mode_o,
    input  wire logic                  servo_irq_i,
    input  wire logic                  dec_status_i,
    output logic                       status_o,
    input  wire logic [SAMPLE_W-1:0]   audio_i,
    input  wire logic                  wclk_i,
    output logic [SAMPLE_W-1:0]        dac_data_o,
    output logic                       dac_wclk_o,
    output logic                       dac_right_first_o,
    output logic signed [5:0]          pll_eq_ns_o,
    input  wire logic                  ebu_i,
    output logic                       ebu_o,
    output logic                       ebu_after_conceal_o,
    output logic                       ebu_flags_o,
    output logic [1:0]                 ebu_accuracy_o,
    input  wire logic                  pll_multiplier_select_i,
    output logic                       xtal_slow_o,
    output logic [3:0]                 speed_factor_o,
    output dsc_pkg::dsc_op_state_t     op_state_o,
    input  wire logic                  int_offtrack_i,
    input  wire logic                  versatile_pin_1_i,
    output logic                       offtrack_o,
    input  wire logic                  mute_l_i,
    input  wire logic                  mute_r_i,
    output logic                       kill_o,
    output logic                       versatile_pin_3_o
);
    import dsc_pkg::*;

    logic [15:0][3:0] bank_reg;
    logic [15:0][3:0] bank_next;
    logic [3:0]       rdata_next;
    logic [1:0]       vp1_sync_reg;
    logic [1:0]       pll_multiplier_select_sync_reg;

    logic [3:0] mo_r;
    logic [3:0] ds_r;
    logic [3:0] eq_r;
    logic [3:0] eb_r;
    logic [3:0] sp_r;
    logic [3:0] vp_r;
    logic [3:0] rg_r;
    logic       vp1;
    logic       pll_multiplier_select;

    assign mo_r   = bank_reg[MOTOR_OUTPUT_CONFIG_OFS];
    assign ds_r   = bank_reg[DAC_STATUS_SELECT_OFS];
    assign eq_r   = bank_reg[PLL_EQUALIZER_OFS];
    assign eb_r   = bank_reg[DIGITAL_AUDIO_OUT_CONFIG_OFS];
    assign sp_r   = bank_reg[SPEED_CONTROL_OFS];
    assign vp_r   = bank_reg[VERSATILE_PIN_CONFIG_OFS];
    assign rg_r   = bank_reg[SPEED_RANGE_OFS];
    assign vp1    = vp1_sync_reg[1];
    assign pll_multiplier_select = pll_multiplier_select_sync_reg[1];

    // Bank writes store the whole nibble at mapped indices; reads answer next cycle.
    always_comb begin
        bank_next  = bank_reg;
        rdata_next = 4'h0;
        if (wr_i && BANK_MAP[addr_i]) begin
            bank_next[addr_i] = wdata_i;
        end
        if (rd_i && BANK_MAP[addr_i]) begin
            rdata_next = bank_reg[addr_i];
        end
    end

    // Storage and pin synchronisers; nothing reads the first stage but the second.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bank_reg        <= BANK_RST;
            rdata_o         <= 4'h0;
            vp1_sync_reg    <= 2'b00;
            pll_multiplier_select_sync_reg <= 2'b00;
        end else begin
            bank_reg        <= bank_next;
            rdata_o         <= rdata_next;
            vp1_sync_reg    <= {vp1_sync_reg[0], versatile_pin_1_i};
            pll_multiplier_select_sync_reg <= {pll_multiplier_select_sync_reg[0], pll_multiplier_select_i};
        end
    end

    // Next values of all decoded outputs.
    logic [7:0]            cap;
    logic [7:0]            lvl;
    dsc_motor_mode_t       mmode;
    logic [7:0]            ma_next;
    logic [7:0]            mb_next;
    logic                  moe_next;
    logic                  stat_next;
    logic [SAMPLE_W-1:0]   dac_next;
    logic                  wclk_next;
    logic signed [5:0]     eq_next;
    logic                  ebu_off;
    logic                  ebu_next;
    logic [1:0]            acc_next;
    logic [3:0]            base;
    logic [3:0]            spd_next;
    dsc_op_state_t         op_next;
    logic                  ot_next;
    logic                  kill_next;
    logic                  v3_next;

    always_comb begin
        // Unlisted cap code 01 falls back to the lowest cap, the safe side.
        case (mo_r[1:0])
            2'b10:   cap = MOTOR_CAP_MID;
            2'b11:   cap = MOTOR_CAP_HI;
            default: cap = MOTOR_CAP_LO;
        endcase
        lvl      = (motor_cmd_i > cap) ? cap : motor_cmd_i;
        mmode    = dsc_motor_mode_t'(mo_r[3:2]);
        moe_next = (mmode == DSC_MOTOR_OFF);
        ma_next  = (moe_next || motor_dir_i) ? 8'h00 : lvl;
        mb_next  = (moe_next || !motor_dir_i) ? 8'h00 : lvl;

        // Code 01 shows pin 1 only while the pin is not the off-track source.
        case (ds_r[1:0])
            2'b10:   stat_next = dec_status_i;
            2'b01:   stat_next = vp_r[VP_EXT_OT_BIT] ? servo_irq_i : vp1;
            2'b11:   stat_next = dec_status_i;
            default: stat_next = servo_irq_i;
        endcase
        dac_next  = ds_r[DAC_INVERT_BIT] ? ~audio_i : audio_i;
        wclk_next = wclk_i ^ ds_r[DAC_SWAP_BIT];

        // Unlisted equalizer codes keep the nominal setting.
        case (eq_r)
            4'h1:    eq_next = EQ_OVER_30;
            4'h2:    eq_next = EQ_OVER_15;
            4'h4:    eq_next = EQ_UNDER_15;
            4'h5:    eq_next = EQ_UNDER_30;
            default: eq_next = EQ_NOMINAL;
        endcase

        // Accuracy is reported as level 1 to 3; 0 while the output is off.
        ebu_off  = eb_r[2] & eb_r[0];
        ebu_next = ebu_off ? 1'b0 : ebu_i;
        case ({eb_r[2], eb_r[0]})
            2'b01:   acc_next = 2'd1;
            2'b10:   acc_next = 2'd3;
            2'b11:   acc_next = 2'd0;
            default: acc_next = 2'd2;
        endcase

        // Speed: range from register E, doubling from bit 3 or the multiplier.
        if (sp_r[SPD_XTAL_BIT]) begin
            base = pll_multiplier_select ? 4'd2 : 4'd1;
        end else begin
            base = sp_r[SPD_DOUBLE_BIT] ? 4'd2 : 4'd1;
        end
        spd_next = rg_r[RANGE_FAST_BIT] ? 4'(base << 2) : base;
        case (sp_r[1:0])
            2'b10:   op_next = DSC_PAUSE_STANDBY;
            2'b11:   op_next = DSC_OPERATING;
            default: op_next = DSC_STOP_STANDBY;
        endcase

        ot_next = vp_r[VP_EXT_OT_BIT] ? vp1 : int_offtrack_i;
        if (!vp_r[VP_SPLIT_BIT]) begin
            kill_next = mute_l_i;
            v3_next   = mute_r_i;
        end else begin
            kill_next = mute_l_i | mute_r_i;
            v3_next   = vp_r[VP_V3_HIGH_BIT] & ~vp_r[3];
        end
    end

    // Output registers; every output leaves from a flip-flop.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            motor_drive_out_a_o <= 8'h00;
            motor_drive_out_b_o <= 8'h00;
            motor_drive_oe_o    <= 1'b1;
            motor_mode_o        <= DSC_MOTOR_OFF;
            status_o            <= 1'b0;
            dac_data_o          <= '0;
            dac_wclk_o          <= 1'b0;
            dac_right_first_o   <= 1'b0;
            pll_eq_ns_o         <= EQ_NOMINAL;
            ebu_o               <= 1'b0;
            ebu_after_conceal_o <= 1'b1;
            ebu_flags_o         <= 1'b0;
            ebu_accuracy_o      <= 2'd2;
            xtal_slow_o         <= 1'b0;
            speed_factor_o      <= 4'd1;
            op_state_o          <= DSC_STOP_STANDBY;
            offtrack_o          <= 1'b0;
            kill_o              <= 1'b0;
            versatile_pin_3_o   <= 1'b0;
        end else begin
            motor_drive_out_a_o <= ma_next;
            motor_drive_out_b_o <= mb_next;
            motor_drive_oe_o    <= moe_next;
            motor_mode_o        <= mmode;
            status_o            <= stat_next;
            dac_data_o          <= dac_next;
            dac_wclk_o          <= wclk_next;
            dac_right_first_o   <= ds_r[DAC_SWAP_BIT];
            pll_eq_ns_o         <= eq_next;
            ebu_o               <= ebu_next;
            ebu_after_conceal_o <= eb_r[EBU_AFTER_BIT];
            ebu_flags_o         <= eb_r[EBU_FLAGS_BIT];
            ebu_accuracy_o      <= acc_next;
            xtal_slow_o         <= sp_r[SPD_XTAL_BIT];
            speed_factor_o      <= spd_next;
            op_state_o          <= op_next;
            offtrack_o          <= ot_next;
            kill_o              <= kill_next;
            versatile_pin_3_o   <= v3_next;
        end
    end

    // Checks of the decoded behaviour.
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence wr_to(logic [3:0] a, logic [3:0] d);
        wr_i && addr_i == a && wdata_i == d;
    endsequence

    motor_cap_a: assert property (
        mo_r[1:0] == 2'b11 && mo_r[3:2] != 2'b00 && !motor_dir_i
        |=> motor_drive_out_a_o == $past(motor_cmd_i))
        else $error("motor output not full scale at cap code 11");

    motor_off_a: assert property (
        wr_to(MOTOR_OUTPUT_CONFIG_OFS, 4'h3) ##1 1'b1
        |=> motor_drive_oe_o && motor_drive_out_a_o == 8'h00 && motor_drive_out_b_o == 8'h00)
        else $error("motor pins driven in off mode");

    status_irq_a: assert property (
        ds_r[1:0] == 2'b00 |=> status_o == $past(servo_irq_i))
        else $error("status pin not showing servo interrupt");

    dac_invert_a: assert property (
        ds_r[DAC_INVERT_BIT] |=> dac_data_o == ~$past(audio_i))
        else $error("DAC samples not inverted");

    wclk_swap_a: assert property (
        $stable(ds_r) |=> dac_wclk_o == ($past(wclk_i) ^ dac_right_first_o))
        else $error("word select polarity does not follow channel order");

    eq_over_a: assert property (
        wr_to(PLL_EQUALIZER_OFS, 4'h1) ##1 1'b1 |=> pll_eq_ns_o == 6'sd30)
        else $error("30 ns over-equalization not applied");

    eq_under_a: assert property (
        wr_to(PLL_EQUALIZER_OFS, 4'h4) ##1 1'b1 |=> pll_eq_ns_o == -6'sd15)
        else $error("15 ns under-equalization not applied");

    ebu_off_a: assert property (
        eb_r[2] && eb_r[0] |=> !ebu_o && ebu_accuracy_o == 2'd0)
        else $error("audio output not held low when off");

    speed_range_a: assert property (
        !sp_r[SPD_XTAL_BIT] && sp_r[SPD_DOUBLE_BIT] && rg_r[RANGE_FAST_BIT] |=> speed_factor_o == 4'd8)
        else $error("eight times speed not selected");

    single_kill_a: assert property (
        vp_r[3:1] == 3'b001 |=> !versatile_pin_3_o && kill_o == ($past(mute_l_i) | $past(mute_r_i)))
        else $error("combined mute not on kill output");

    ot_source_a: assert property (
        vp_r[VP_EXT_OT_BIT] |=> offtrack_o == $past(vp1))
        else $error("off-track not taken from pin 1");

    write_store_a: assert property (
        wr_i && BANK_MAP[addr_i] ##1 rd_i && addr_i == $past(addr_i) && !wr_i
        |=> rdata_o == $past(wdata_i, 2))
        else $error("written nibble not read back");

endmodule
`default_nettype wire

/* File: tb/test_decoder_servo_config_regs.sv */
// Self-checking testbench for the decoder and servo configuration bank.
`timescale 1ns/1ps
`default_nettype none
module test_decoder_servo_config_regs;
    import dsc_pkg::*;
    logic            ref_clk_i = 1'b0;
    logic            nrst_i = 1'b0;
    logic [3:0]      addr_i = 4'h0;
    logic [3:0]      wdata_i = 4'h0;
    logic            wr_i = 1'b0;
    logic            rd_i = 1'b0;
    logic [7:0]      motor_cmd_i = 8'h00;
    logic            motor_dir_i = 1'b0;
    logic            servo_irq_i = 1'b0;
    logic            dec_status_i = 1'b0;
    logic [15:0]     audio_i = 16'h0000;
    logic            wclk_i = 1'b0;
    logic            ebu_i = 1'b0;
    logic            pll_multiplier_select_i = 1'b0;
    logic            int_offtrack_i = 1'b0;
    logic            versatile_pin_1_i = 1'b0;
    logic            mute_l_i = 1'b1;
    logic            mute_r_i = 1'b0;
    logic [3:0]      rdata_o;
    logic [7:0]      out_a;
    logic [7:0]      out_b;
    logic            oe;
    dsc_motor_mode_t mode;
    logic            status_o;
    logic [15:0]     dac_data_o;
    logic            dac_wclk_o;
    logic            right_first;
    logic [5:0]      eq_ns;
    logic            ebu_o;
    logic            after_conceal;
    logic            flags;
    logic [1:0]      accuracy;
    logic            xtal_slow;
    logic [3:0]      speed;
    dsc_op_state_t   op_state;
    logic            offtrack_o;
    logic            kill_o;
    logic            pin3;
    int              err_total = 0;
    int              checked = 0;
    int              cycles = 0;

    dsc_config_regs #(.SAMPLE_W(16)) dut_u (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .motor_cmd_i(motor_cmd_i), .motor_dir_i(motor_dir_i),
        .motor_drive_out_a_o(out_a), .motor_drive_out_b_o(out_b), .motor_drive_oe_o(oe),
        .motor_mode_o(mode), .servo_irq_i(servo_irq_i), .dec_status_i(dec_status_i), .status_o(status_o),
        .audio_i(audio_i), .wclk_i(wclk_i), .dac_data_o(dac_data_o), .dac_wclk_o(dac_wclk_o),
        .dac_right_first_o(right_first), .pll_eq_ns_o(eq_ns), .ebu_i(ebu_i), .ebu_o(ebu_o),
        .ebu_after_conceal_o(after_conceal), .ebu_flags_o(flags), .ebu_accuracy_o(accuracy),
        .pll_multiplier_select_i(pll_multiplier_select_i), .xtal_slow_o(xtal_slow),
        .speed_factor_o(speed), .op_state_o(op_state), .int_offtrack_i(int_offtrack_i),
        .versatile_pin_1_i(versatile_pin_1_i), .offtrack_o(offtrack_o), .mute_l_i(mute_l_i),
        .mute_r_i(mute_r_i), .kill_o(kill_o), .versatile_pin_3_o(pin3)
    );

    // Free-running 25 MHz clock.
    always #20 ref_clk_i = ~ref_clk_i;

    // Case equality so that an unknown never passes as a match.
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One-cycle write, then wait long enough for decoded outputs and synchronised pins to settle.
    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #1;
    endtask

    // One-cycle read; data is valid only in the following cycle.
    task automatic rd(input logic [3:0] a, input logic [3:0] exp);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        chk("rdata", {12'h0, exp}, {12'h0, rdata_o});
        @(posedge ref_clk_i);
        #1;
        chk("rdata idle", 16'h0, {12'h0, rdata_o});
    endtask

    task automatic print_verdict();
        $display("Counts: %0d comparisons, %0d mismatches", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic t_reset();
        logic [3:0] idx [8] = '{4'h6, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'h0};
        logic [3:0] val [8] = '{4'h0, 4'h0, 4'h3, 4'h2, 4'h0, 4'h2, 4'h4, 4'h0};
        #1;
        chk("oe", 16'h1, {15'h0, oe});
        chk("mode", 16'h0, {14'h0, mode});
        chk("eq", 16'h0, {10'h0, eq_ns});
        chk("after", 16'h1, {15'h0, after_conceal});
        chk("accuracy", 16'h2, {14'h0, accuracy});
        chk("op", 16'h0, {14'h0, op_state});
        chk("speed", 16'h1, {12'h0, speed});
        chk("pin3", 16'h0, {15'h0, pin3});
        chk("kill", 16'h1, {15'h0, kill_o});
        for (int i = 0; i < 8; i++) rd(idx[i], val[i]);
        $display("test reset done");
    endtask

    task automatic t_motor();
        logic [7:0] caps [3] = '{8'd94, 8'd191, 8'd255};
        logic [1:0] cc [3] = '{2'b00, 2'b10, 2'b11};
        logic [7:0] e;
        @(posedge ref_clk_i);
        motor_cmd_i <= 8'hc0;
        for (int m = 0; m < 4; m++) begin
            for (int c = 0; c < 3; c++) begin
                wr(MOTOR_OUTPUT_CONFIG_OFS, {m[1:0], cc[c]});
                e = (m == 0) ? 8'h0 : ((caps[c] < 8'hc0) ? caps[c] : 8'hc0);
                chk("motor a", {8'h0, e}, {8'h0, out_a});
                chk("motor b", 16'h0, {8'h0, out_b});
                chk("motor oe", {15'h0, m == 0}, {15'h0, oe});
                chk("motor mode", {14'h0, m[1:0]}, {14'h0, mode});
            end
        end
        // Reverse direction moves the drive to the other pin.
        @(posedge ref_clk_i);
        motor_dir_i <= 1'b1;
        wr(MOTOR_OUTPUT_CONFIG_OFS, 4'h6);
        chk("motor b dir", 16'h00bf, {8'h0, out_b});
        chk("motor a dir", 16'h0, {8'h0, out_a});
        $display("test motor done");
    endtask

    task automatic t_dac();
        logic [3:0] codes [5] = '{4'h0, 4'h2, 4'h4, 4'h8, 4'he};
        logic [3:0] c;
        @(posedge ref_clk_i);
        servo_irq_i <= 1'b1;
        audio_i <= 16'h1234;
        wclk_i <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            c = codes[i];
            wr(DAC_STATUS_SELECT_OFS, c);
            chk("status", {15'h0, c[1:0] != 2'b10}, {15'h0, status_o});
            chk("dac data", c[2] ? 16'hedcb : 16'h1234, dac_data_o);
            chk("dac wclk", {15'h0, ~c[3]}, {15'h0, dac_wclk_o});
            chk("right first", {15'h0, c[3]}, {15'h0, right_first});
        end
        $display("test dac done");
    endtask

    task automatic t_eq();
        logic [3:0] codes [5] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h3};
        logic [5:0] eqs [5] = '{6'd30, 6'd15, 6'h31, 6'h22, 6'd0};
        for (int i = 0; i < 5; i++) begin
            wr(PLL_EQUALIZER_OFS, codes[i]);
            chk("eq", {10'h0, eqs[i]}, {10'h0, eq_ns});
        end
        $display("test equalizer done");
    endtask

    task automatic t_ebu();
        logic [1:0] acct [4] = '{2'd2, 2'd1, 2'd3, 2'd0};
        logic [3:0] c;
        for (int i = 0; i < 16; i++) begin
            c = i[3:0];
            // Stream level varies with the code, so both a stuck output and a missed turn-off show.
            @(posedge ref_clk_i);
            ebu_i <= c[2];
            wr(DIGITAL_AUDIO_OUT_CONFIG_OFS, c);
            chk("after", {15'h0, c[1]}, {15'h0, after_conceal});
            chk("flags", {15'h0, c[3]}, {15'h0, flags});
            chk("accuracy", {14'h0, acct[{c[2], c[0]}]}, {14'h0, accuracy});
            chk("ebu out", {15'h0, c[2] & ~(c[2] & c[0])}, {15'h0, ebu_o});
        end
        $display("test ebu done");
    endtask

    task automatic t_speed();
        logic [3:0] codes [6] = '{4'h0, 4'h2, 4'h3, 4'hb, 4'h7, 4'hf};
        logic [1:0] opt [4] = '{2'b00, 2'b00, 2'b01, 2'b11};
        logic [3:0] c;
        logic [3:0] f;
        for (int e = 0; e < 2; e++) begin
            wr(SPEED_RANGE_OFS, {e[0], 3'b100});
            for (int p = 0; p < 2; p++) begin
                @(posedge ref_clk_i);
                pll_multiplier_select_i <= p[0];
                for (int i = 0; i < 6; i++) begin
                    c = codes[i];
                    wr(SPEED_CONTROL_OFS, c);
                    f = c[2] ? (p[0] ? 4'd2 : 4'd1) : (c[3] ? 4'd2 : 4'd1);
                    f = e[0] ? f << 2 : f;
                    chk("speed", {12'h0, f}, {12'h0, speed});
                    chk("xtal", {15'h0, c[2]}, {15'h0, xtal_slow});
                    chk("op", {14'h0, opt[c[1:0]]}, {14'h0, op_state});
                end
            end
        end
        $display("test speed done");
    endtask

    task automatic t_pins();
        logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6};
        logic [3:0] c;
        logic a;
        for (int k = 0; k < 2; k++) begin
            a = (k == 0);
            @(posedge ref_clk_i);
            servo_irq_i <= 1'b0;
            mute_l_i <= a;
            mute_r_i <= ~a;
            int_offtrack_i <= a;
            versatile_pin_1_i <= ~a;
            for (int i = 0; i < 5; i++) begin
                c = codes[i];
                wr(VERSATILE_PIN_CONFIG_OFS, c);
                chk("offtrack", {15'h0, c[0] ? ~a : a}, {15'h0, offtrack_o});
                chk("kill", {15'h0, c[1] ? 1'b1 : a}, {15'h0, kill_o});
                chk("pin3", {15'h0, c[1] ? c[2] : ~a}, {15'h0, pin3});
            end
        end
        // Internal off-track selected, so pin 1 may be seen on the status output.
        wr(DAC_STATUS_SELECT_OFS, 4'h1);
        chk("status pin1", 16'h1, {15'h0, status_o});
        $display("test pins done");
    endtask

    task automatic t_update();
        wr(SPEED_CONTROL_OFS, 4'h0);
        @(posedge ref_clk_i);
        addr_i <= SPEED_CONTROL_OFS;
        wdata_i <= 4'h3;
        wr_i <= 1'b1;
        // A read straight after the write must already see the new nibble.
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        #1;
        chk("op held", 16'h0, {14'h0, op_state});
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        chk("op new", 16'h3, {14'h0, op_state});
        chk("rdata after write", 16'h3, {12'h0, rdata_o});
        rd(SPEED_CONTROL_OFS, 4'h3);
        wr(4'h1, 4'hf);
        rd(4'h1, 4'h0);
        $display("test update done");
    endtask

    // Guard against a hang; the whole run needs well under this many cycles.
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_total++;
            print_verdict();
        end
    end

    initial begin
        repeat (5) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        t_reset();
        t_motor();
        t_dac();
        t_eq();
        t_ebu();
        t_speed();
        t_pins();
        t_update();
        print_verdict();
    end
endmodule
`default_nettype wire
